/* File: rtl/dppio_regs.vh */
// Purpose: Register offsets, field positions, reset values and mode codes for dppio_core
// Assumes: Included by its bare name; definitions only
// Notes:   Data is 8 bits wide; addresses are 4-bit word indices
`ifndef DPPIO_REGS_VH
`define DPPIO_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define DPPIO_ADDR_DATA_A    4'h0
`define DPPIO_ADDR_DATA_B    4'h1
`define DPPIO_ADDR_CTRL      4'h2
`define DPPIO_ADDR_DIR_A     4'h3
`define DPPIO_ADDR_DIR_B     4'h4
`define DPPIO_ADDR_HS_DIR    4'h5
`define DPPIO_ADDR_HS_DATA   4'h6
`define DPPIO_ADDR_STATUS    4'h7
`define DPPIO_ADDR_MASK      4'h8

////////////////////////////////////////////////////////////////////////////////
// Port modes, control byte fields
`define DPPIO_MODE_IN        2'h0
`define DPPIO_MODE_OUT       2'h1
`define DPPIO_MODE_BIDIR     2'h2
`define DPPIO_MODE_BIT       2'h3
`define DPPIO_CTRL_A_LSB     0
`define DPPIO_CTRL_B_LSB     2

////////////////////////////////////////////////////////////////////////////////
// Status and mask bit positions
`define DPPIO_ST_A_IN        0
`define DPPIO_ST_B_IN        1
`define DPPIO_ST_A_OUT       2
`define DPPIO_ST_B_OUT       3

////////////////////////////////////////////////////////////////////////////////
// Handshake pin positions
`define DPPIO_HS_A_RDY       0
`define DPPIO_HS_A_STB       1
`define DPPIO_HS_B_RDY       2
`define DPPIO_HS_B_STB       3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define DPPIO_RST_BYTE       8'h00
`define DPPIO_RST_NIB        4'h0
`define DPPIO_RST_MODE       2'h3

`endif

/* File: rtl/dppio_core.v */
// Purpose: Two 8-bit programmable parallel ports with ready/strobe handshakes
// Assumes: All inputs but rst_i synchronous to clk_i; rst_i async; strobes and timing pulse active high
// Notes:   Output enables are active low; the bench resolves the pin wires
`timescale 1ns/1ns
`include "dppio_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Ports A and B each selectable as byte input or byte output with handshake.
// - Bidirectional mode exists on port A only; a request for B is ignored.
// - Bidirectional port A moves both directions over its eight data pins.
// - Bidirectional A uses A handshake inbound and B handshake outbound.
// - Bit-programmable mode gives every data line its own direction bit.
// - Handshake pins have per-pin direction when used as general lines.
// - Bus interface works identically whether mapped in I/O or memory space.
// - Strobe lead drops ready; trail latches data and raises service request.
// - Buffer read: timing pulse lead clears request, its trail raises ready.
module dppio_core (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	input  wire       cs_i,
	input  wire [3:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       we_i,
	input  wire       re_i,
	output wire [7:0] rdata_o,
	input  wire       cpu_timing_pulse_i,
	input  wire [7:0] a_in_i,
	output wire [7:0] a_out_o,
	output wire [7:0] a_oe_n_o,
	input  wire [7:0] b_in_i,
	output wire [7:0] b_out_o,
	output wire [7:0] b_oe_n_o,
	input  wire [3:0] hs_in_i,
	output wire [3:0] hs_out_o,
	output wire [3:0] hs_oe_n_o,
	output wire       a_srq_o,
	output wire       b_srq_o,
	output wire       irq_o
);

	reg  [1:0] mode_a;
	reg  [1:0] mode_b;
	reg  [7:0] dir_a;
	reg  [7:0] dir_b;
	reg  [3:0] hs_dir;
	reg  [3:0] hs_lat;
	reg  [7:0] out_a;
	reg  [7:0] out_b;
	reg  [7:0] buf_a;
	reg  [7:0] buf_b;
	reg        rdy_a;
	reg        rdy_b;
	reg        pend_a;
	reg        pend_b;
	reg  [3:0] status;
	reg  [3:0] mask;
	reg        strb_a_q;
	reg        strb_b_q;
	reg        tpb_q;
	reg  [7:0] rdata;
	reg  [7:0] next_rdata;
	reg  [7:0] a_oe_n;
	reg  [7:0] b_oe_n;
	wire [3:0] next_status;
	wire [3:0] st_set;
	wire [3:0] st_clr;
	wire [1:0] next_mode_b;

	////////////////////////////////////////////////////////////////////////
	// Merge driven latch bits with pin levels for bit-programmable reads
	function [7:0] dppio_merge;
		input [7:0] dir;
		input [7:0] lat;
		input [7:0] pins;
		begin
			dppio_merge = (dir & lat) | (~dir & pins);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode; chip select and clock enable alone qualify, so I/O or memory mapping looks the same
	wire acc_ok  = cs_i & ce_i;
	wire wr      = acc_ok & we_i;
	wire rd      = acc_ok & re_i;
	wire wr_a    = wr & (addr_i == `DPPIO_ADDR_DATA_A);
	wire wr_b    = wr & (addr_i == `DPPIO_ADDR_DATA_B);
	wire rd_a    = rd & (addr_i == `DPPIO_ADDR_DATA_A);
	wire rd_b    = rd & (addr_i == `DPPIO_ADDR_DATA_B);
	wire wr_ctrl = wr & (addr_i == `DPPIO_ADDR_CTRL);

	// Control byte selects modes; B never takes bidirectional
	wire [1:0] req_a = wdata_i[`DPPIO_CTRL_A_LSB+1:`DPPIO_CTRL_A_LSB];
	wire [1:0] req_b = wdata_i[`DPPIO_CTRL_B_LSB+1:`DPPIO_CTRL_B_LSB];
	assign next_mode_b = (req_b == `DPPIO_MODE_BIDIR) ? mode_b : req_b;

	////////////////////////////////////////////////////////////////////////
	// Handshake engines
	wire a_bidir  = (mode_a == `DPPIO_MODE_BIDIR);
	wire a_in_en  = (mode_a == `DPPIO_MODE_IN) | a_bidir;
	wire a_out_en = (mode_a == `DPPIO_MODE_OUT) | a_bidir;
	wire b_in_en  = (mode_b == `DPPIO_MODE_IN);
	wire b_out_en = (mode_b == `DPPIO_MODE_OUT);

	wire strb_a   = hs_in_i[`DPPIO_HS_A_STB];
	wire strb_b   = hs_in_i[`DPPIO_HS_B_STB];
	// Outbound A watches the B strobe when bidirectional
	wire a_ostb   = a_bidir ? strb_b : strb_a;
	wire a_ostb_q = a_bidir ? strb_b_q : strb_a_q;

	wire a_in_lead  = a_in_en & strb_a & ~strb_a_q;
	wire a_in_trail = a_in_en & ~strb_a & strb_a_q;
	wire b_in_lead  = b_in_en & strb_b & ~strb_b_q;
	wire b_in_trail = b_in_en & ~strb_b & strb_b_q;
	wire a_out_trl  = a_out_en & ~a_ostb & a_ostb_q;
	wire b_out_trl  = b_out_en & ~strb_b & strb_b_q;
	wire tpb_rise   = cpu_timing_pulse_i & ~tpb_q;
	wire tpb_fall   = ~cpu_timing_pulse_i & tpb_q;

	////////////////////////////////////////////////////////////////////////
	// Sticky status; a hardware set in the clearing cycle wins
	assign st_set = {b_out_trl, a_out_trl, b_in_trail, a_in_trail};
	assign st_clr = ({4{wr & (addr_i == `DPPIO_ADDR_STATUS)}} & wdata_i[3:0])
		| {wr_b, wr_a, pend_b & tpb_rise, pend_a & tpb_rise};
	assign next_status = (status & ~st_clr) | st_set;

	////////////////////////////////////////////////////////////////////////
	// Read data mux
	// Idle cycles read zero, so several slaves may share one OR-ed return bus
	always @* begin
		next_rdata = `DPPIO_RST_BYTE;
		if (rd) begin
			case (addr_i)
			`DPPIO_ADDR_DATA_A: begin
				case (mode_a)
				`DPPIO_MODE_IN:    next_rdata = buf_a;
				`DPPIO_MODE_BIDIR: next_rdata = buf_a;
				`DPPIO_MODE_OUT:   next_rdata = out_a;
				default:           next_rdata = dppio_merge(dir_a, out_a, a_in_i);
				endcase
			end
			`DPPIO_ADDR_DATA_B: begin
				case (mode_b)
				`DPPIO_MODE_IN:  next_rdata = buf_b;
				`DPPIO_MODE_OUT: next_rdata = out_b;
				default:         next_rdata = dppio_merge(dir_b, out_b, b_in_i);
				endcase
			end
			`DPPIO_ADDR_CTRL:    next_rdata = {4'h0, mode_b, mode_a};
			`DPPIO_ADDR_DIR_A:   next_rdata = dir_a;
			`DPPIO_ADDR_DIR_B:   next_rdata = dir_b;
			`DPPIO_ADDR_HS_DIR:  next_rdata = {4'h0, hs_dir};
			`DPPIO_ADDR_HS_DATA: next_rdata = {4'h0, hs_in_i};
			`DPPIO_ADDR_STATUS:  next_rdata = {4'h0, status};
			`DPPIO_ADDR_MASK:    next_rdata = {4'h0, mask};
			default:             next_rdata = `DPPIO_RST_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_a   <= `DPPIO_RST_MODE;
			mode_b   <= `DPPIO_RST_MODE;
			dir_a    <= `DPPIO_RST_BYTE;
			dir_b    <= `DPPIO_RST_BYTE;
			hs_dir   <= `DPPIO_RST_NIB;
			hs_lat   <= `DPPIO_RST_NIB;
			out_a    <= `DPPIO_RST_BYTE;
			out_b    <= `DPPIO_RST_BYTE;
			buf_a    <= `DPPIO_RST_BYTE;
			buf_b    <= `DPPIO_RST_BYTE;
			rdy_a    <= 1'b0;
			rdy_b    <= 1'b0;
			pend_a   <= 1'b0;
			pend_b   <= 1'b0;
			status   <= `DPPIO_RST_NIB;
			mask     <= `DPPIO_RST_NIB;
			strb_a_q <= 1'b0;
			strb_b_q <= 1'b0;
			tpb_q    <= 1'b0;
			rdata    <= `DPPIO_RST_BYTE;
		end else if (ce_i) begin
			strb_a_q <= strb_a;
			strb_b_q <= strb_b;
			tpb_q    <= cpu_timing_pulse_i;
			rdata    <= next_rdata;
			status   <= next_status;
			if (wr & (addr_i == `DPPIO_ADDR_DIR_A))
				dir_a <= wdata_i;
			if (wr & (addr_i == `DPPIO_ADDR_DIR_B))
				dir_b <= wdata_i;
			if (wr & (addr_i == `DPPIO_ADDR_HS_DIR))
				hs_dir <= wdata_i[3:0];
			if (wr & (addr_i == `DPPIO_ADDR_HS_DATA))
				hs_lat <= wdata_i[3:0];
			if (wr & (addr_i == `DPPIO_ADDR_MASK))
				mask <= wdata_i[3:0];
			if (wr_a)
				out_a <= wdata_i;
			if (wr_b)
				out_b <= wdata_i;
			if (a_in_trail)
				buf_a <= a_in_i;
			if (b_in_trail)
				buf_b <= b_in_i;

			// Only a read of a buffer in input service arms the timing pulse
			// A pulse with nothing pending leaves ready alone, so stray pulses invite no byte
			if (rd_a & a_in_en)
				pend_a <= 1'b1;
			else if (tpb_fall)
				pend_a <= 1'b0;
			if (rd_b & b_in_en)
				pend_b <= 1'b1;
			else if (tpb_fall)
				pend_b <= 1'b0;

			// Port A ready pin: inbound in input or bidir, outbound in output mode
			if (a_in_lead | (mode_a == `DPPIO_MODE_OUT & a_out_trl))
				rdy_a <= 1'b0;
			else if (a_in_en & pend_a & tpb_fall)
				rdy_a <= 1'b1;
			else if (mode_a == `DPPIO_MODE_OUT & wr_a)
				rdy_a <= 1'b1;

			// Port B ready pin; carries A outbound while A is bidirectional
			if (a_bidir) begin
				if (a_out_trl)
					rdy_b <= 1'b0;
				else if (wr_a)
					rdy_b <= 1'b1;
			end else if (b_in_lead | b_out_trl)
				rdy_b <= 1'b0;
			else if (b_in_en & pend_b & tpb_fall)
				rdy_b <= 1'b1;
			else if (b_out_en & wr_b)
				rdy_b <= 1'b1;

			// A new mode starts with ready low; a discarded read raises it for input, a data write for output
			if (wr_ctrl) begin
				mode_a <= req_a;
				mode_b <= next_mode_b;
				if (req_a != mode_a)
					rdy_a <= 1'b0;
				if ((next_mode_b != mode_b) | (req_a != mode_a))
					rdy_b <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	always @* begin
		case (mode_a)
		`DPPIO_MODE_OUT:   a_oe_n = 8'h00;
		`DPPIO_MODE_IN:    a_oe_n = 8'hff;
		// Driven only while the peripheral strobes the outbound side
		`DPPIO_MODE_BIDIR: a_oe_n = strb_b ? 8'h00 : 8'hff;
		default:           a_oe_n = ~dir_a;
		endcase
		case (mode_b)
		`DPPIO_MODE_OUT: b_oe_n = 8'h00;
		`DPPIO_MODE_IN:  b_oe_n = 8'hff;
		default:         b_oe_n = ~dir_b;
		endcase
	end

	// B handshake pins belong to A outbound in bidir; software keeps B bit-programmed then
	wire hs_byte_a = (mode_a != `DPPIO_MODE_BIT);
	wire hs_byte_b = (mode_b != `DPPIO_MODE_BIT) | a_bidir;

	assign hs_oe_n_o[`DPPIO_HS_A_RDY] = hs_byte_a ? 1'b0 : ~hs_dir[`DPPIO_HS_A_RDY];
	assign hs_oe_n_o[`DPPIO_HS_A_STB] = hs_byte_a ? 1'b1 : ~hs_dir[`DPPIO_HS_A_STB];
	assign hs_oe_n_o[`DPPIO_HS_B_RDY] = hs_byte_b ? 1'b0 : ~hs_dir[`DPPIO_HS_B_RDY];
	assign hs_oe_n_o[`DPPIO_HS_B_STB] = hs_byte_b ? 1'b1 : ~hs_dir[`DPPIO_HS_B_STB];
	assign hs_out_o[`DPPIO_HS_A_RDY]  = hs_byte_a ? rdy_a : hs_lat[`DPPIO_HS_A_RDY];
	assign hs_out_o[`DPPIO_HS_A_STB]  = hs_lat[`DPPIO_HS_A_STB];
	assign hs_out_o[`DPPIO_HS_B_RDY]  = hs_byte_b ? rdy_b : hs_lat[`DPPIO_HS_B_RDY];
	assign hs_out_o[`DPPIO_HS_B_STB]  = hs_lat[`DPPIO_HS_B_STB];

	assign a_out_o  = out_a;
	assign b_out_o  = out_b;
	assign a_oe_n_o = a_oe_n;
	assign b_oe_n_o = b_oe_n;
	assign rdata_o  = rdata;

	////////////////////////////////////////////////////////////////////////
	// Service requests and masked interrupt
	assign a_srq_o = status[`DPPIO_ST_A_IN] | status[`DPPIO_ST_A_OUT];
	assign b_srq_o = status[`DPPIO_ST_B_IN] | status[`DPPIO_ST_B_OUT];
	assign irq_o   = |(status & mask);

endmodule

/* File: tb/dppio_props.sv */
// Purpose: Port checks for dppio_core
// Assumes: One clock; reset async, active high
// Notes:   Mode shadows follow control writes as software sees them
`timescale 1ns/1ns
`include "dppio_regs.vh"
module dppio_props (
	input wire       clk_i,
	input wire       rst_i,
	input wire       ce_i,
	input wire       cs_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       we_i,
	input wire       re_i,
	input wire [7:0] rdata_o,
	input wire [3:0] hs_in_i,
	input wire [3:0] hs_out_o,
	input wire [3:0] hs_oe_n_o,
	input wire [7:0] a_oe_n_o,
	input wire [7:0] b_oe_n_o,
	input wire       a_srq_o,
	input wire       b_srq_o,
	input wire       irq_o
);
	wire      wr_c = cs_i & ce_i & we_i & (addr_i == `DPPIO_ADDR_CTRL);
	reg [1:0] mode_a;
	reg [1:0] mode_b;
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_a <= `DPPIO_RST_MODE;
			mode_b <= `DPPIO_RST_MODE;
		end else if (wr_c) begin
			mode_a <= wdata_i[1:0];
			if (wdata_i[3:2] != `DPPIO_MODE_BIDIR)
				mode_b <= wdata_i[3:2];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	a_reset_inputs: assert property (disable iff (1'b0) rst_i |->
		a_oe_n_o == 8'hff && b_oe_n_o == 8'hff && hs_oe_n_o == 4'hf
		&& !a_srq_o && !b_srq_o && !irq_o)
		else $error("pin driven or request up in reset");
	a_rdata_idle: assert property (!$past(cs_i & ce_i & re_i) |-> rdata_o == 8'h00)
		else $error("read data outside read answer cycle");
	a_in_float: assert property (mode_a == `DPPIO_MODE_IN |-> a_oe_n_o == 8'hff)
		else $error("input port drives pins");
	a_out_drive: assert property (mode_a == `DPPIO_MODE_OUT |-> a_oe_n_o == 8'h00)
		else $error("output port not driving");
	a_bidir_drive: assert property (mode_a == `DPPIO_MODE_BIDIR |->
		a_oe_n_o == {8{~hs_in_i[`DPPIO_HS_B_STB]}})
		else $error("bidir drive not tied to B strobe");
	a_b_no_bidir: assert property (cs_i && ce_i && re_i && addr_i == `DPPIO_ADDR_CTRL |=>
		rdata_o[3:0] == {mode_b, mode_a})
		else $error("port B took bidir request");
	a_stb_ready: assert property (mode_a == `DPPIO_MODE_IN && $rose(hs_in_i[1]) |=>
		!hs_out_o[`DPPIO_HS_A_RDY])
		else $error("ready not dropped on strobe lead");
	a_stb_srq: assert property (mode_a == `DPPIO_MODE_IN && $fell(hs_in_i[1]) |=> a_srq_o)
		else $error("no request after strobe trail");
	a_irq_src: assert property (irq_o |-> a_srq_o || b_srq_o)
		else $error("interrupt without request");
	cover property (mode_a == `DPPIO_MODE_IN && $fell(hs_in_i[1]));
	cover property (mode_a == `DPPIO_MODE_BIDIR && !a_oe_n_o[0]);
	cover property (irq_o);
endmodule
bind dppio_core dppio_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cs_i(cs_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .hs_in_i(hs_in_i),
	.hs_out_o(hs_out_o), .hs_oe_n_o(hs_oe_n_o), .a_oe_n_o(a_oe_n_o), .b_oe_n_o(b_oe_n_o),
	.a_srq_o(a_srq_o), .b_srq_o(b_srq_o), .irq_o(irq_o));

/* File: tb/dppio_periph.sv */
// Purpose: Peripheral sending bytes into port A with a strobe pulse
// Assumes: Byte held until the strobe trail has been sampled
// Notes:   Released lines show the inverse of the last byte, not a stale copy
`timescale 1ns/1ns
module dppio_periph (
	input  wire       clk_i,
	input  wire       send_i,
	input  wire [7:0] byte_i,
	input  wire [7:0] oe_n_i,
	input  wire [7:0] out_i,
	output wire [7:0] pins_o,
	output reg        stb_o
);
	reg [7:0] drv = 8'h00;
	reg [1:0] st  = 2'h0;
	initial stb_o = 1'b0;
	assign pins_o = (~oe_n_i & out_i) | (oe_n_i & drv);
	always @(posedge clk_i) begin
		case (st)
		2'h0: if (send_i) begin
			drv <= byte_i;
			stb_o <= 1'b1;
			st <= 2'h1;
		end
		2'h1: begin
			stb_o <= 1'b0;
			st <= 2'h2;
		end
		2'h2: st <= 2'h3;
		default: begin
			drv <= ~drv;
			st <= 2'h0;
		end
		endcase
	end
endmodule

/* File: tb/dppio_core_tb.sv */
// Purpose: Self-checking bench for dppio_core
// Assumes: Bus driven by non-blocking assignment after rising edges
// Notes:   Clock enable held high; frozen-clock behaviour stays untested
`timescale 1ns/1ns
`include "dppio_regs.vh"
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", n, e, v); end end
module dppio_core_tb;
	reg        clk_i = 0;
	reg        rst_i = 0;
	reg        ce_i = 1;
	reg        cs_i = 1;
	reg  [3:0] addr_i = 0;
	reg  [7:0] wdata_i = 0;
	reg        we_i = 0;
	reg        re_i = 0;
	reg        cpu_timing_pulse_i = 0;
	reg  [3:0] hs_drv = 4'h0;
	reg        send = 0;
	reg  [7:0] sbyte = 0;
	wire [7:0] rdata_o, a_out_o, a_oe_n_o, a_in_i, b_out_o, b_oe_n_o, b_in_i;
	wire [3:0] hs_out_o, hs_oe_n_o, hs_in_i;
	wire       a_srq_o, b_srq_o, irq_o, stb;
	integer    error_cnt = 0;
	integer    compares = 0;
	integer    cyc = 0;
	assign b_in_i = (~b_oe_n_o & b_out_o) | (b_oe_n_o & 8'h33);
	assign hs_in_i = (~hs_oe_n_o & hs_out_o) | (hs_oe_n_o & (hs_drv | {2'h0, stb, 1'b0}));
	dppio_core dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cs_i(cs_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.cpu_timing_pulse_i(cpu_timing_pulse_i),
		.a_in_i(a_in_i), .a_out_o(a_out_o), .a_oe_n_o(a_oe_n_o),
		.b_in_i(b_in_i), .b_out_o(b_out_o), .b_oe_n_o(b_oe_n_o),
		.hs_in_i(hs_in_i), .hs_out_o(hs_out_o), .hs_oe_n_o(hs_oe_n_o),
		.a_srq_o(a_srq_o), .b_srq_o(b_srq_o), .irq_o(irq_o));
	dppio_periph per_u (.clk_i(clk_i), .send_i(send), .byte_i(sbyte), .oe_n_i(a_oe_n_o),
		.out_i(a_out_o), .pins_o(a_in_i), .stb_o(stb));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			addr_i <= a;
			wdata_i <= d;
			we_i <= 1'b1;
			@(posedge clk_i);
			we_i <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(posedge clk_i);
			addr_i <= a;
			re_i <= 1'b1;
			@(posedge clk_i);
			re_i <= 1'b0;
			#1 `CHK("rdata", e, rdata_o)
		end
	endtask
	task cpu_timing_pulse(input s, input r);
		begin
			@(posedge clk_i);
			cpu_timing_pulse_i <= 1'b1;
			@(posedge clk_i);
			cpu_timing_pulse_i <= 1'b0;
			#1 `CHK("srq", s, a_srq_o)
			@(posedge clk_i);
			#1 `CHK("ready", r, hs_out_o[0])
		end
	endtask
	task snd(input [7:0] b);
		integer i;
		begin
			@(posedge clk_i);
			sbyte <= b;
			send <= 1'b1;
			@(posedge clk_i);
			send <= 1'b0;
			for (i = 0; i < 20 && a_srq_o !== 1'b1; i = i + 1) begin
				@(posedge clk_i);
				#1;
			end
			`CHK("srq", 1'b1, a_srq_o)
			`CHK("ready", 1'b0, hs_out_o[0])
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		begin
			`CHK("a oe", 8'hff, a_oe_n_o)
			`CHK("hs oe", 4'hf, hs_oe_n_o)
			rd(`DPPIO_ADDR_CTRL, 8'h0f);
			rd(`DPPIO_ADDR_STATUS, 8'h00);
			rd(4'hf, 8'h00);
			$display("t_reset done");
		end
	endtask
	task t_input;
		begin
			wr(`DPPIO_ADDR_CTRL, 8'h0c);
			#1 `CHK("ready", 1'b0, hs_out_o[0])
			@(posedge clk_i);
			addr_i <= `DPPIO_ADDR_DATA_A;
			re_i <= 1'b1;
			@(posedge clk_i);
			re_i <= 1'b0;
			cpu_timing_pulse(1'b0, 1'b1);
			wr(`DPPIO_ADDR_MASK, 8'h01);
			snd(8'hc3);
			`CHK("irq", 1'b1, irq_o)
			rd(`DPPIO_ADDR_DATA_A, 8'hc3);
			cpu_timing_pulse(1'b0, 1'b1);
			wr(`DPPIO_ADDR_MASK, 8'h00);
			snd(8'h3c);
			`CHK("irq", 1'b0, irq_o)
			wr(`DPPIO_ADDR_STATUS, 8'h01);
			#1 `CHK("srq", 1'b0, a_srq_o)
			$display("t_input done");
		end
	endtask
	task t_output;
		begin
			wr(`DPPIO_ADDR_CTRL, 8'h05);
			wr(`DPPIO_ADDR_DATA_A, 8'h96);
			wr(`DPPIO_ADDR_DATA_B, 8'h3c);
			#1 `CHK("a out", 8'h96, a_out_o)
			`CHK("b out", 8'h3c, b_out_o)
			`CHK("b oe", 8'h00, b_oe_n_o)
			`CHK("hs out", 4'h5, hs_out_o & 4'h5)
			@(posedge clk_i);
			hs_drv[1] <= 1'b1;
			@(posedge clk_i);
			hs_drv[1] <= 1'b0;
			@(posedge clk_i);
			#1 `CHK("a ready", 1'b0, hs_out_o[0])
			rd(`DPPIO_ADDR_STATUS, 8'h04);
			$display("t_output done");
		end
	endtask
	task t_bidir;
		begin
			wr(`DPPIO_ADDR_CTRL, 8'h0e);
			wr(`DPPIO_ADDR_DATA_A, 8'ha5);
			#1 `CHK("a oe", 8'hff, a_oe_n_o)
			@(posedge clk_i);
			hs_drv[3] <= 1'b1;
			#1 `CHK("a pins", 8'ha5, a_in_i)
			`CHK("b ready", 1'b1, hs_out_o[2])
			@(posedge clk_i);
			hs_drv[3] <= 1'b0;
			@(posedge clk_i);
			#1 `CHK("b ready", 1'b0, hs_out_o[2])
			rd(`DPPIO_ADDR_STATUS, 8'h04);
			wr(`DPPIO_ADDR_STATUS, 8'h04);
			snd(8'h69);
			rd(`DPPIO_ADDR_DATA_A, 8'h69);
			wr(`DPPIO_ADDR_CTRL, 8'h0a);
			rd(`DPPIO_ADDR_CTRL, 8'h0e);
			$display("t_bidir done");
		end
	endtask
	task t_b_input;
		begin
			wr(`DPPIO_ADDR_CTRL, 8'h03);
			#1 `CHK("b srq", 1'b0, b_srq_o)
			@(posedge clk_i);
			hs_drv[3] <= 1'b1;
			@(posedge clk_i);
			hs_drv[3] <= 1'b0;
			@(posedge clk_i);
			#1 `CHK("b srq", 1'b1, b_srq_o)
			`CHK("b ready", 1'b0, hs_out_o[2])
			rd(`DPPIO_ADDR_DATA_B, 8'h33);
			$display("t_b_input done");
		end
	endtask
	task t_bits;
		begin
			@(posedge clk_i);
			hs_drv <= 4'h8;
			wr(`DPPIO_ADDR_CTRL, 8'h0f);
			wr(`DPPIO_ADDR_DIR_A, 8'hf0);
			wr(`DPPIO_ADDR_DIR_B, 8'h0f);
			wr(`DPPIO_ADDR_DATA_B, 8'hcc);
			wr(`DPPIO_ADDR_HS_DIR, 8'h05);
			wr(`DPPIO_ADDR_HS_DATA, 8'h01);
			#1 `CHK("a oe", 8'h0f, a_oe_n_o)
			`CHK("b oe", 8'hf0, b_oe_n_o)
			`CHK("hs oe", 4'ha, hs_oe_n_o)
			rd(`DPPIO_ADDR_DATA_B, 8'h3c);
			rd(`DPPIO_ADDR_HS_DATA, 8'h09);
			$display("t_bits done");
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		begin
			$display("compares %0d error_cnt %0d", compares, error_cnt);
			if (error_cnt == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim;
		end
	end
	initial begin
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_input;
		t_output;
		t_bidir;
		t_b_input;
		t_bits;
		end_sim;
	end
endmodule
